// [rtl/dpsw_decoder.sv]
// Purpose: serial control word capture and supply switch decode, two slots
// Assumes: link clock idles from last bit until latch has been seen here
// Notes:   levels are encoded selections; the analog switches sit outside
//
// Local design decisions: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps

module dpsw_decoder #(
  parameter int WORD_W = dpsw_pkg::WORD_BITS
) (
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic                  clkEn,
  // serial link
  input  wire logic                  linkClk,
  input  wire logic                  serialData,
  input  wire logic                  serialLatch,
  // pins
  input  wire logic                  modeSelect,
  input  wire logic                  resetHigh,
  input  wire logic                  resetLow_n,
  // Avalon-MM slave
  input  wire logic [3:0]            address,
  input  wire logic                  read,
  input  wire logic                  write,
  input  wire logic [31:0]           writedata,
  output logic      [31:0]           readdata,
  output logic                       waitrequest,
  // switch selections
  output dpsw_pkg::dpsw_level_t      slotACoreLevel,
  output dpsw_pkg::dpsw_level_t      slotAProgLevel,
  output dpsw_pkg::dpsw_level_t      slotBCoreLevel,
  output dpsw_pkg::dpsw_level_t      slotBProgLevel
);

  // bit positions in the package only describe the 11-bit word
  if (WORD_W != dpsw_pkg::WORD_BITS) begin : g_bad_width
    $error("word width must be 11");
  end

  // ---------------- link domain ----------------
  logic [WORD_W-1:0] shiftQ;
  logic [WORD_W-1:0] shiftD;

  // first bit shifted in ends at bit 0
  assign shiftD = {serialData, shiftQ[WORD_W-1:1]};

  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      shiftQ <= '0;
    end else begin
      shiftQ <= shiftD;
    end
  end

  // ---------------- pin synchronisers ----------------
  logic [3:0] pinMetaQ;
  logic [3:0] pinSyncQ;
  logic [3:0] pinRaw;

  assign pinRaw = {serialLatch, modeSelect, resetHigh, ~resetLow_n};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pinMetaQ <= 4'h0;
      pinSyncQ <= 4'h0;
    end else if (clkEn) begin
      pinMetaQ <= pinRaw;
      pinSyncQ <= pinMetaQ;
    end
  end

  logic latchSync;
  logic modeSync;
  logic pinReset;
  logic latchPrevQ;
  logic latchRise;

  assign latchSync = pinSyncQ[3];
  assign modeSync  = pinSyncQ[2];
  assign pinReset  = pinSyncQ[1] | pinSyncQ[0];
  assign latchRise = latchSync & ~latchPrevQ;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      latchPrevQ <= 1'b0;
    end else if (clkEn) begin
      latchPrevQ <= latchSync;
    end
  end

  // ---------------- register bus ----------------
  dpsw_pkg::dpsw_busreq_t req;
  logic waitQ;
  logic accept;
  logic doWrite;
  logic [31:0] readD;
  logic [31:0] readQ;
  logic ctrlDischargeQ;

  assign req.read      = read;
  assign req.write     = write;
  assign req.address   = address;
  assign req.writedata = writedata;

  // one wait cycle keeps read data registered
  assign accept  = (req.read | req.write) & waitQ;
  assign doWrite = req.write & ~waitQ;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      waitQ <= 1'b1;
    end else if (clkEn) begin
      waitQ <= ~accept;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrlDischargeQ <= dpsw_pkg::CTRL_DISCHARGE_RESET;
    end else if (clkEn && doWrite && req.address == dpsw_pkg::OFF_CTRL) begin
      ctrlDischargeQ <= req.writedata[0];
    end
  end

  // ---------------- latched word and discharge ----------------
  logic              holdReset;
  logic              dischargeQ;
  logic [WORD_W-1:0] wordQ;
  logic              loadWord;

  // software discharge acts like a reset pin
  assign holdReset = pinReset | ctrlDischargeQ;
  // no latching while reset is held
  assign loadWord  = latchRise & ~holdReset;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wordQ <= dpsw_pkg::WORD_RESET;
    end else if (clkEn && loadWord) begin
      // shift register is quiet here: link clock waits for the latch
      wordQ <= shiftQ;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dischargeQ <= 1'b1;
    end else if (clkEn) begin
      if (holdReset) begin
        dischargeQ <= 1'b1;
      end else if (loadWord) begin
        dischargeQ <= 1'b0;
      end
    end
  end

  // ---------------- decode ----------------
  function automatic dpsw_pkg::dpsw_level_t coreSel(
    input logic hi,
    input logic lo
  );
    dpsw_pkg::dpsw_level_t r;
    r = dpsw_pkg::DPSW_LVL_0V;
    case ({hi, lo})
      2'b01:   r = dpsw_pkg::DPSW_LVL_3V3;
      2'b10:   r = dpsw_pkg::DPSW_LVL_5V;
      default: r = dpsw_pkg::DPSW_LVL_0V;
    endcase
    return r;
  endfunction : coreSel

  function automatic dpsw_pkg::dpsw_level_t progSel(
    input logic                  hi,
    input logic                  lo,
    input logic                  indep,
    input logic                  sel5v,
    input dpsw_pkg::dpsw_level_t core
  );
    dpsw_pkg::dpsw_level_t r;
    r = dpsw_pkg::DPSW_LVL_0V;
    case ({hi, lo})
      2'b00:   r = dpsw_pkg::DPSW_LVL_0V;
      2'b01: begin
        if (indep) begin
          r = sel5v ? dpsw_pkg::DPSW_LVL_5V : dpsw_pkg::DPSW_LVL_3V3;
        end else begin
          r = core;
        end
      end
      2'b10:   r = dpsw_pkg::DPSW_LVL_12V;
      default: r = dpsw_pkg::DPSW_LVL_HIZ;
    endcase
    return r;
  endfunction : progSel

  dpsw_pkg::dpsw_slot_t slotA;
  dpsw_pkg::dpsw_slot_t slotB;
  dpsw_pkg::dpsw_slot_t outAD;
  dpsw_pkg::dpsw_slot_t outBD;
  dpsw_pkg::dpsw_slot_t groundAll;
  dpsw_pkg::dpsw_slot_t floatAll;
  logic                 powered;

  assign slotA.core = coreSel(wordQ[dpsw_pkg::BIT_A_CORE_HI],
                              wordQ[dpsw_pkg::BIT_A_CORE_LO]);
  assign slotB.core = coreSel(wordQ[dpsw_pkg::BIT_B_CORE_HI],
                              wordQ[dpsw_pkg::BIT_B_CORE_LO]);
  // mode high picks independent decode, low the dependent one
  assign slotA.prog = progSel(wordQ[dpsw_pkg::BIT_A_PROG_HI],
                              wordQ[dpsw_pkg::BIT_A_PROG_LO], modeSync,
                              wordQ[dpsw_pkg::BIT_A_PROG_5V], slotA.core);
  assign slotB.prog = progSel(wordQ[dpsw_pkg::BIT_B_PROG_HI],
                              wordQ[dpsw_pkg::BIT_B_PROG_LO], modeSync,
                              wordQ[dpsw_pkg::BIT_B_PROG_5V], slotB.core);

  assign powered   = wordQ[dpsw_pkg::BIT_POWER_DOWN];
  assign groundAll = '{core: dpsw_pkg::DPSW_LVL_0V, prog: dpsw_pkg::DPSW_LVL_0V};
  assign floatAll  = '{core: dpsw_pkg::DPSW_LVL_HIZ, prog: dpsw_pkg::DPSW_LVL_HIZ};

  // discharge outranks power-down; the held word and the synced mode pin feed this
  assign outAD = dischargeQ ? groundAll : (powered ? slotA : floatAll);
  assign outBD = dischargeQ ? groundAll : (powered ? slotB : floatAll);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      slotACoreLevel <= dpsw_pkg::DPSW_LVL_0V;
      slotAProgLevel <= dpsw_pkg::DPSW_LVL_0V;
      slotBCoreLevel <= dpsw_pkg::DPSW_LVL_0V;
      slotBProgLevel <= dpsw_pkg::DPSW_LVL_0V;
    end else if (clkEn) begin
      slotACoreLevel <= outAD.core;
      slotAProgLevel <= outAD.prog;
      slotBCoreLevel <= outBD.core;
      slotBProgLevel <= outBD.prog;
    end
  end

  // ---------------- read path ----------------
  logic [31:0] statusWord;

  assign statusWord = {16'h0000,
                       slotBProgLevel, slotBCoreLevel,
                       slotAProgLevel, slotACoreLevel,
                       1'b0, modeSync, pinReset, dischargeQ};

  always_comb begin
    readD = 32'h0000_0000;
    case (req.address)
      dpsw_pkg::OFF_CTRL:   readD = {31'h0000_0000, ctrlDischargeQ};
      dpsw_pkg::OFF_STATUS: readD = statusWord;
      dpsw_pkg::OFF_WORD:   readD = {21'h00_0000, wordQ};
      default:              readD = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      readQ <= 32'h0000_0000;
    end else if (clkEn && accept && req.read) begin
      readQ <= readD;
    end
  end

  assign readdata    = readQ;
  assign waitrequest = waitQ;

endmodule : dpsw_decoder

// [rtl/dpsw_pkg.sv]
// Purpose: shared constants and types of the dual slot power switch decoder
// Assumes: 11-bit serial control word, bit D0 shifted in first
// Notes:   register map on a 32-bit Avalon-MM slave, byte addresses
package dpsw_pkg;

  localparam int WORD_BITS = 11;

  // control word bit positions
  localparam int BIT_A_PROG_HI = 0;
  localparam int BIT_A_PROG_LO = 1;
  localparam int BIT_A_CORE_HI = 3;
  localparam int BIT_A_CORE_LO = 2;
  localparam int BIT_B_PROG_HI = 4;
  localparam int BIT_B_PROG_LO = 5;
  localparam int BIT_B_CORE_HI = 6;
  localparam int BIT_B_CORE_LO = 7;
  localparam int BIT_POWER_DOWN = 8;
  localparam int BIT_A_PROG_5V = 9;
  localparam int BIT_B_PROG_5V = 10;

  // register byte offsets
  localparam logic [3:0] OFF_CTRL   = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_WORD   = 4'h8;

  // reset values
  localparam logic [10:0] WORD_RESET = 11'h000;
  localparam logic        CTRL_DISCHARGE_RESET = 1'b0;

  // bus answer latency in clock cycles after the request edge
  localparam int BUS_WAIT_CYCLES = 1;

  typedef enum logic [2:0] {
    DPSW_LVL_0V   = 3'b000,
    DPSW_LVL_3V3  = 3'b001,
    DPSW_LVL_5V   = 3'b010,
    DPSW_LVL_12V  = 3'b011,
    DPSW_LVL_HIZ  = 3'b100
  } dpsw_level_t;

  typedef struct packed {
    dpsw_level_t core;
    dpsw_level_t prog;
  } dpsw_slot_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
  } dpsw_busreq_t;

endpackage : dpsw_pkg

// [verif/dpsw_decoder_asserts.sv]
// Purpose: port checks of the switch decoder
// Assumes: clkEn held high
// Notes:   pin resets pass a 2FF sync, so waits carry slack
`timescale 1ns/1ps
module dpsw_decoder_asserts (
  input wire logic             clock,
  input wire logic             rst_n,
  input wire logic             read,
  input wire logic             write,
  input wire logic             waitrequest,
  input wire logic             serialLatch,
  input wire logic             modeSelect,
  input wire logic             resetHigh,
  input wire logic             resetLow_n,
  input dpsw_pkg::dpsw_level_t slotACoreLevel,
  input dpsw_pkg::dpsw_level_t slotAProgLevel,
  input dpsw_pkg::dpsw_level_t slotBCoreLevel,
  input dpsw_pkg::dpsw_level_t slotBProgLevel
);
  wire [11:0] lv = {slotACoreLevel, slotAProgLevel, slotBCoreLevel, slotBProgLevel};
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence ask_s; (read || write) && waitrequest; endsequence
  sequence quiet_s; (!serialLatch && !write && resetLow_n && !resetHigh && $stable(modeSelect)) [*8]; endsequence
  sequence dep_s; (!modeSelect) [*6]; endsequence
  bus_answer_a: assert property (ask_s |=> !waitrequest) else $error("bus answer late");
  wait_one_a: assert property (!waitrequest |=> waitrequest) else $error("waitrequest low too long");
  idle_wait_a: assert property (!read && !write |-> waitrequest) else $error("answer without request");
  reset_ground_a: assert property ($rose(rst_n) |-> lv == 12'h000) else $error("not grounded");
  float_all_a: assert property (slotACoreLevel == dpsw_pkg::DPSW_LVL_HIZ |-> lv == 12'h924)
    else $error("partial float");
  core_range_a: assert property (slotACoreLevel != dpsw_pkg::DPSW_LVL_12V
    && slotBCoreLevel != dpsw_pkg::DPSW_LVL_12V) else $error("core at 12V");
  pin_high_a: assert property (resetHigh [*5] |-> lv == 12'h000) else $error("high reset ignored");
  pin_low_a: assert property (!resetLow_n [*5] |-> lv == 12'h000) else $error("low reset ignored");
  hold_word_a: assert property (quiet_s |=> $stable(lv)) else $error("levels moved");
  dep_follow_a: assert property (dep_s ##0 (slotAProgLevel == dpsw_pkg::DPSW_LVL_5V
    || slotAProgLevel == dpsw_pkg::DPSW_LVL_3V3) |-> slotAProgLevel == slotACoreLevel) else $error("no follow");
endmodule : dpsw_decoder_asserts
bind dpsw_decoder dpsw_decoder_asserts i_dpsw_decoder_asserts (.clock, .rst_n, .read, .write, .waitrequest,
  .serialLatch, .modeSelect, .resetHigh, .resetLow_n, .slotACoreLevel, .slotAProgLevel, .slotBCoreLevel,
  .slotBProgLevel);

// [verif/dpsw_link_model.sv]
// Purpose: card controller on the serial link
// Assumes: 6 ns link clock, running only within frames
// Notes:   latch held long so the word crossing stays safe
`timescale 1ns/1ps
module dpsw_link_model (
  input wire logic        go,
  input wire logic        doLatch,
  input wire logic [10:0] word,
  output logic            linkClk,
  output logic            serialData,
  output logic            serialLatch,
  output logic            busy
);
  // one process drives every pin, so no two writers race
  initial begin
    linkClk = 1'b0;
    serialData = 1'b0;
    serialLatch = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge go);
      busy = 1'b1;
      #1.7;
      for (int i = 0; i < 11; i++) begin
        serialData = word[i];
        #3 linkClk = 1'b1;
        #3 linkClk = 1'b0;
      end
      serialData = ~serialData;
      if (doLatch) begin
        #1 serialLatch = 1'b1;
        #30 serialLatch = 1'b0;
      end
      #30 busy = 1'b0;
    end
  end
endmodule : dpsw_link_model

// [verif/dpsw_decoder_tb.sv]
// Purpose: self-checking bench of the switch decoder
// Assumes: clkEn tied high; link model drives the serial pins
// Notes:   levels packed as A core, A prog, B core, B prog
`timescale 1ns/1ps
module dpsw_decoder_tb;
  logic clock = 1'b0, rst_n = 1'b0, clkEn = 1'b1, modeSelect = 1'b0, resetHigh = 1'b0, resetLow_n = 1'b1;
  logic read = 1'b0, write = 1'b0, go = 1'b0, doLatch = 1'b0, linkClk, serialData, serialLatch, busy;
  logic [3:0] address = 4'h0;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic [10:0] wordIn = 11'h000, lastW;
  logic waitrequest;
  dpsw_pkg::dpsw_level_t slotACoreLevel, slotAProgLevel, slotBCoreLevel, slotBProgLevel;
  wire [11:0] lv = {slotACoreLevel, slotAProgLevel, slotBCoreLevel, slotBProgLevel};
  int bad_count = 0, n_checks = 0;
  dpsw_decoder i_dpsw_decoder (.clock, .rst_n, .clkEn, .linkClk, .serialData, .serialLatch, .modeSelect,
    .resetHigh, .resetLow_n, .address, .read, .write, .writedata, .readdata, .waitrequest, .slotACoreLevel,
    .slotAProgLevel, .slotBCoreLevel, .slotBProgLevel);
  dpsw_link_model i_dpsw_link_model (.go, .doLatch, .word(wordIn), .linkClk, .serialData, .serialLatch, .busy);
  always #2.5 clock = ~clock;
  function automatic logic [2:0] core(logic h, logic l);
    return (h ^ l) ? {1'b0, h, l} : 3'h0;
  endfunction : core
  function automatic logic [2:0] prog(logic h, logic l, logic m, logic s, logic [2:0] c);
    return {h, l} == 2'h0 ? 3'h0 : {h, l} == 2'h2 ? 3'h3 : {h, l} == 2'h3 ? 3'h4 : m ? (s ? 3'h2 : 3'h1) : c;
  endfunction : prog
  function automatic logic [31:0] expLv(logic [10:0] w, logic m);
    logic [2:0] ca, cb;
    ca = core(w[3], w[2]);
    cb = core(w[6], w[7]);
    if (!w[8]) return 32'h924;
    return {20'h0, ca, prog(w[0], w[1], m, w[9], ca), cb, prog(w[4], w[5], m, w[10], cb)};
  endfunction : expLv
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask : bus
  task automatic send(input logic [10:0] w, input logic l);
    wordIn <= w;
    doLatch <= l;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    while (busy !== 1'b0) @(posedge clock);
    if (l) lastW = w;
  endtask : send
  task automatic t_decode;
    logic [10:0] w;
    for (int m = 0; m < 2; m++) begin
      modeSelect <= m[0];
      for (int i = 0; i <= 16; i++) begin
        w = {i[2], i[1], i != 16, i[3:2], i[1:0], i[1:0] ^ i[3:2], i[3:2]};
        send(w, 1'b1);
        check({20'h0, lv}, expLv(w, m[0]));
        bus(1'b0, dpsw_pkg::OFF_WORD, 32'h0);
        check(q, {21'h0, w});
      end
    end
    send(11'h2AA, 1'b0);
    check({20'h0, lv}, expLv(lastW, 1'b1));
    $display("decode test done");
  endtask : t_decode
  task automatic t_pins;
    for (int k = 0; k < 2; k++) begin
      if (k == 0) resetHigh <= 1'b1;
      else resetLow_n <= 1'b0;
      repeat (6) @(posedge clock);
      check({20'h0, lv}, 32'h0);
      send(11'h115, 1'b1);
      resetHigh <= 1'b0;
      resetLow_n <= 1'b1;
      repeat (8) @(posedge clock);
      check({20'h0, lv}, 32'h0);
      send(11'h116, 1'b1);
      check({20'h0, lv}, expLv(11'h116, modeSelect));
    end
    $display("pin reset test done");
  endtask : t_pins
  task automatic t_regs;
    logic [31:0] e;
    e = expLv(lastW, modeSelect);
    bus(1'b0, dpsw_pkg::OFF_STATUS, 32'h0);
    check(q, {16'h0, e[2:0], e[5:3], e[8:6], e[11:9], 1'b0, modeSelect, 2'h0});
    bus(1'b0, dpsw_pkg::OFF_CTRL, 32'h0);
    check(q, 32'h0);
    bus(1'b1, dpsw_pkg::OFF_CTRL, 32'h1);
    repeat (4) @(posedge clock);
    check({20'h0, lv}, 32'h0);
    bus(1'b0, dpsw_pkg::OFF_STATUS, 32'h0);
    check(q, {29'h0, modeSelect, 2'h1});
    bus(1'b1, dpsw_pkg::OFF_WORD, 32'h7FF);
    bus(1'b0, dpsw_pkg::OFF_WORD, 32'h0);
    check(q, {21'h0, lastW});
    bus(1'b0, 4'hC, 32'h0);
    check(q, 32'h0);
    bus(1'b1, dpsw_pkg::OFF_CTRL, 32'h0);
    send(11'h1A5, 1'b1);
    check({20'h0, lv}, expLv(11'h1A5, modeSelect));
    $display("register test done");
  endtask : t_regs
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  initial begin
    #150000;
    bad_count++;
    results();
  end
  initial begin
    repeat (12) @(posedge clock);
    check({20'h0, lv}, 32'h0);
    rst_n <= 1'b1;
    @(posedge clock);
    t_decode();
    t_pins();
    t_regs();
    results();
  end
endmodule : dpsw_decoder_tb
